// ==== dv/hrr_reg_store.sv ====
// register store model standing behind the read slave's fetch port
// assumes one clock shared with the slave; answers the cycle after a fetch pulse
`default_nettype none

module hrr_reg_store (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire hrr_pkg::hrr_rd_t rd,
    output logic [15:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    import hrr_pkg::*;

    function automatic logic [15:0] reg_val(input logic [15:0] a);
        return (a == 16'h03eb) ? 16'h1770 : (a == 16'h03ec) ? 16'h0bb8 :
               (a == 16'h03ed) ? 16'h03e8 : (a ^ 16'h5a3c);
    endfunction

    // outside the answer cycle the value inverts every cycle, so a sample one cycle late cannot pass
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 16'h0000;
        end else if (rd.en) begin
            rd_data <= reg_val(rd.addr);
        end else begin
            rd_data <= ~rd_data;
        end
    end
endmodule // hrr_reg_store

`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the holding-register read slave
// assumes hrr_reg_store as fetch partner; the bench plays the remote master
`include "hrr_params.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import hrr_pkg::*;

    logic ref_clk, rstn, tx_ready, tx_valid, tx_last, wr_allowed, frame_err;
    logic [7:0] my_addr, tx_data;
    logic [15:0] rd_data, wr_chk_addr, n;
    hrr_rx_t rx;
    hrr_rd_t rd;
    logic [8:0] exp_q[$];
    logic [7:0] fcs[$] = '{8'h01, 8'h04, 8'h06, 8'h08, 8'h10, 8'h46, 8'hff};
    logic [15:0] wa[$] = '{16'h00c7, 16'h00c8, 16'h012b, 16'h012c, 16'h01f2, 16'h01f3,
                           16'h01fa, 16'h01fb, 16'h0000, 16'hffff};
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_ferr = 0;
    int n_ferr_exp = 0;
    integer seed = 32'hc63f7975;

    hrr_read_slave dut (.ref_clk(ref_clk), .rstn(rstn), .my_addr(my_addr), .rx(rx),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
        .rd(rd), .rd_data(rd_data), .wr_chk_addr(wr_chk_addr), .wr_allowed(wr_allowed),
        .frame_err(frame_err));
    hrr_reg_store store (.ref_clk(ref_clk), .rstn(rstn), .rd(rd), .rd_data(rd_data));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] reg_val(input logic [15:0] a);
        return (a == 16'h03eb) ? 16'h1770 : (a == 16'h03ec) ? 16'h0bb8 :
               (a == 16'h03ed) ? 16'h03e8 : (a ^ 16'h5a3c);
    endfunction

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction

    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (e !== g) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic expect_resp(input logic [7:0] r[$]);
        logic [15:0] c;
        c = crc16(r);
        r.push_back(c[7:0]);
        r.push_back(c[15:8]);
        foreach (r[i]) exp_q.push_back({i == r.size() - 1, r[i]});
    endtask

    task automatic send(input logic [7:0] q[$], input bit bad);
        logic [15:0] c;
        c = crc16(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            @(posedge ref_clk);
            #10;
            rx = '{valid: 1'b1, eof: (i == q.size() - 1), data: q[i]};
        end
        @(posedge ref_clk);
        #10;
        rx = '0;
        for (int k = 0; k < 600 && exp_q.size() != 0; k++) @(posedge ref_clk);
        check("pending bytes", 16'h0000, 16'(exp_q.size()));
        repeat (12) @(posedge ref_clk);
    endtask

    task automatic read_q(input logic [7:0] a, input logic [15:0] st, input logic [15:0] cnt);
        logic [7:0] q[$];
        logic [7:0] r[$];
        logic [15:0] v;
        q = '{a, 8'h03, st[15:8], st[7:0], cnt[15:8], cnt[7:0]};
        if (cnt >= 16'd1 && cnt <= 16'd10) begin
            r = '{a, 8'h03, 8'(cnt * 2)};
            for (int i = 0; i < cnt; i++) begin
                v = reg_val(16'(st + i));
                r.push_back(v[15:8]);
                r.push_back(v[7:0]);
            end
        end else begin
            r = '{a, 8'h83, 8'h03};
        end
        if (a == my_addr && a != 8'h00 && a <= 8'hf7) expect_resp(r);
        send(q, 1'b0);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, stalling sink, monitor, timeout
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        tx_ready = 1'b0;
        forever begin
            @(posedge ref_clk);
            #10;
            tx_ready = ({$random(seed)} % 4) != 0;
        end
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (frame_err === 1'b1) n_ferr++;
        if (rstn === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected tx byte", 16'h0100, 16'(tx_data));
            end else begin
                check("tx_data", 16'(exp_q[0][7:0]), 16'(tx_data));
                check("tx_last", 16'(exp_q[0][8]), 16'(tx_last));
                void'(exp_q.pop_front());
            end
        end
        if (cyc == 40000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        rx = '0;
        my_addr = 8'h11;
        wr_chk_addr = 16'h0000;
        repeat (10) @(posedge ref_clk);
        #10;
        rstn = 1'b1;
        read_q(8'h11, 16'h03eb, 16'd3);
        read_q(8'h11, 16'h0000, 16'd1);
        read_q(8'h11, 16'h00c8, 16'd10);
        read_q(8'h11, 16'h01f3, 16'd8);
        read_q(8'h11, 16'h0010, 16'd0);
        read_q(8'h11, 16'h0010, 16'd11);
        read_q(8'h11, 16'h0010, 16'd125);
        foreach (fcs[i]) begin
            expect_resp('{8'h11, fcs[i] | 8'h80, 8'h01});
            send('{8'h11, fcs[i], 8'h00, 8'h01, 8'h00, 8'h01}, 1'b0);
        end
        expect_resp('{8'h11, 8'h83, 8'h03});
        send('{8'h11, 8'h03, 8'h00, 8'h00, 8'h00}, 1'b0);
        n_ferr_exp++;
        send('{8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b1);
        send('{8'h11}, 1'b1);
        #10;
        my_addr = 8'h00;
        read_q(8'h00, 16'h0000, 16'd2);
        #10;
        my_addr = 8'h11;
        read_q(8'h12, 16'h0000, 16'd2);
        #10;
        my_addr = 8'hf8;
        read_q(8'hf8, 16'h0000, 16'd2);
        #10;
        my_addr = 8'hf7;
        read_q(8'hf7, 16'h0100, 16'd2);
        repeat (20) begin
            n = 16'(1 + ({$random(seed)} % 10));
            read_q(8'hf7, 16'($random(seed)), n);
        end
        repeat (6) wa.push_back(16'($random(seed)) & 16'h03ff);
        foreach (wa[i]) begin
            #10;
            wr_chk_addr = wa[i];
            @(posedge ref_clk);
            #1;
            check("wr_allowed", 16'(!((wa[i] >= `HRR_MON_FIRST && wa[i] <= `HRR_MON_LAST) ||
                (wa[i] >= `HRR_FLT_FIRST && wa[i] <= `HRR_FLT_LAST))), 16'(wr_allowed));
            @(posedge ref_clk);
        end
        check("frame_err count", 16'(n_ferr_exp), 16'(n_ferr));
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire

// ==== verilog/hrr_params.svh ====
// constants for the holding-register read slave
// assumes byte framing and frame-end detection happen upstream
`ifndef HRR_PARAMS_SVH
`define HRR_PARAMS_SVH

// ----------------------------------------
// protocol codes
// ----------------------------------------
`define HRR_FC_READ 8'h03
`define HRR_ERR_FLAG 8'h80
`define HRR_EXC_FUNC 8'h01
`define HRR_EXC_VALUE 8'h03
`define HRR_BCAST_ADDR 8'h00
`define HRR_MAX_STATION 8'hf7

// ----------------------------------------
// frame layout
// ----------------------------------------
`define HRR_BC_MIN 8'h02
`define HRR_BC_MAX 8'h14
`define HRR_QUERY_LEN 4'h8
`define HRR_MIN_FRAME 4'h4
`define HRR_HDR_LEN 8'h03
`define HRR_ERR_LEN 8'h05
`define HRR_CRC_LEN 8'h02
`define HRR_BUF_DEPTH 8

// ----------------------------------------
// crc
// ----------------------------------------
`define HRR_CRC_PRESET 16'hffff
`define HRR_CRC_POLY 16'ha001

// ----------------------------------------
// read-only register classes (register index ranges)
// ----------------------------------------
`define HRR_MON_FIRST 16'h00c8
`define HRR_MON_LAST 16'h012b
`define HRR_FLT_FIRST 16'h01f3
`define HRR_FLT_LAST 16'h01fa

`endif

// ==== verilog/hrr_pkg.sv ====
// types and the crc step for the holding-register read slave
// assumes hrr_params.svh is on the include path
`include "hrr_params.svh"
`default_nettype none

package hrr_pkg;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_CHECK = 3'b001,
        S_TX    = 3'b010,
        S_FETCH = 3'b011,
        S_LOAD  = 3'b100
    } hrr_state_t;

    typedef struct packed {
        logic valid;
        logic eof;
        logic [7:0] data;
    } hrr_rx_t;

    typedef struct packed {
        logic en;
        logic [15:0] addr;
    } hrr_rd_t;

    // reflected crc, one byte, low bit first
    function automatic logic [15:0] hrr_crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `HRR_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

endpackage : hrr_pkg

`default_nettype wire

// ==== verilog/hrr_read_slave.sv ====
// holding-register read slave: frame check, read query, normal and error responses
// assumes byte stream in with a frame-end pulse, register store answering one cycle later
//
// Behaviour
// - frame ends in a two-byte crc, low byte first then high byte
// - crc recomputed over received frame and compared; mismatch marks a frame of four or more bytes erroneous
// - read query: address, function 03, start hi/lo, count hi/lo, crc
// - read query to address 0 is never treated as a valid read
// - start field is register number minus 40001, used directly as index
// - response byte count is twice the register count, range 02 to 14
// - register data high byte first, registers in ascending address order
// - normal response: address, function 03, byte count, data, crc
// - reads reach every register class without filtering
// - single writes allowed only outside monitor and fault-history classes
// - error response function byte is 80 plus received function
// - unsupported function code yields an error response
// - station addresses are 1 to 247, 0 is broadcast
`include "hrr_params.svh"
`default_nettype none

module hrr_read_slave (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] my_addr,
    input wire hrr_pkg::hrr_rx_t rx,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_last,
    output hrr_pkg::hrr_rd_t rd,
    input wire logic [15:0] rd_data,
    input wire logic [15:0] wr_chk_addr,
    output logic wr_allowed,
    output logic frame_err
);
    import hrr_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    hrr_state_t state_reg, state_next;
    logic [7:0] buf_reg [`HRR_BUF_DEPTH];
    logic [7:0] buf_next [`HRR_BUF_DEPTH];
    logic [3:0] len_reg, len_next;
    logic [15:0] crc_reg, crc_next, crc_d1_reg, crc_d1_next, crc_d2_reg, crc_d2_next;
    logic [7:0] last1_reg, last1_next, last2_reg, last2_next;
    logic [7:0] pos_reg, pos_next, tot_reg, tot_next;
    logic err_reg, err_next;
    logic [7:0] exc_reg, exc_next;
    logic [15:0] word_reg, word_next, rd_addr_reg, rd_addr_next;
    logic [7:0] tx_data_reg, tx_data_next;
    logic wr_allowed_reg, wr_allowed_next, frame_err_reg, frame_err_next;

    // ----------------------------------------
    // query decode
    // ----------------------------------------
    logic rx_take, crc_ok, len_ok, addr_ok, drop, err_func, cnt_ok, err_val;
    logic [7:0] bc;
    logic [15:0] start_idx, crc_fed;
    logic [7:0] p, rel;
    logic tx_fire;

    assign rx_take = (state_reg == S_IDLE) && rx.valid;
    assign crc_ok = (crc_d2_reg == {last1_reg, last2_reg});
    assign len_ok = (len_reg >= `HRR_MIN_FRAME);
    assign addr_ok = (buf_reg[0] == my_addr) && (buf_reg[0] != `HRR_BCAST_ADDR)
                     && (my_addr <= `HRR_MAX_STATION);
    assign drop = !len_ok || !crc_ok || !addr_ok;
    assign err_func = (buf_reg[1] != `HRR_FC_READ);
    assign bc = {buf_reg[5][6:0], 1'b0};
    assign cnt_ok = (buf_reg[4] == 8'h00) && !buf_reg[5][7]
                    && (bc >= `HRR_BC_MIN) && (bc <= `HRR_BC_MAX);
    assign err_val = (len_reg != `HRR_QUERY_LEN) || !cnt_ok;
    assign start_idx = {buf_reg[2], buf_reg[3]};
    assign crc_fed = hrr_crc_byte(crc_reg, tx_data_reg);
    assign tx_fire = (state_reg == S_TX) && tx_ready;
    assign p = pos_reg + 8'h01;
    assign rel = p - `HRR_HDR_LEN;

    // ----------------------------------------
    // frame buffer entries
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `HRR_BUF_DEPTH; gi++) begin : g_buf
            assign buf_next[gi] = (rx_take && (len_reg == 4'(gi))) ? rx.data : buf_reg[gi];
        end
    endgenerate

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        len_next = len_reg;
        crc_next = crc_reg;
        crc_d1_next = crc_d1_reg;
        crc_d2_next = crc_d2_reg;
        last1_next = last1_reg;
        last2_next = last2_reg;
        pos_next = pos_reg;
        tot_next = tot_reg;
        err_next = err_reg;
        exc_next = exc_reg;
        word_next = word_reg;
        rd_addr_next = rd_addr_reg;
        tx_data_next = tx_data_reg;
        frame_err_next = 1'b0;
        // monitor and fault-history registers refuse single writes
        wr_allowed_next = !((wr_chk_addr >= `HRR_MON_FIRST) && (wr_chk_addr <= `HRR_MON_LAST))
                          && !((wr_chk_addr >= `HRR_FLT_FIRST) && (wr_chk_addr <= `HRR_FLT_LAST));
        case (state_reg)
            S_IDLE: begin
                if (rx.valid) begin
                    if (len_reg != 4'hf) begin
                        len_next = len_reg + 4'h1;
                    end
                    crc_next = hrr_crc_byte(crc_reg, rx.data);
                    crc_d1_next = crc_reg;
                    crc_d2_next = crc_d1_reg;
                    last1_next = rx.data;
                    last2_next = last1_reg;
                end
                if (rx.eof) begin
                    state_next = S_CHECK;
                end
            end
            S_CHECK: begin
                frame_err_next = len_ok && !crc_ok;
                len_next = 4'h0;
                crc_next = `HRR_CRC_PRESET;
                if (drop) begin
                    state_next = S_IDLE;
                end else begin
                    err_next = err_func || err_val;
                    exc_next = err_func ? `HRR_EXC_FUNC : `HRR_EXC_VALUE;
                    tot_next = (err_func || err_val) ? `HRR_ERR_LEN
                               : (`HRR_ERR_LEN + bc);
                    pos_next = 8'h00;
                    tx_data_next = buf_reg[0];
                    state_next = S_TX;
                end
            end
            S_TX: begin
                if (tx_ready) begin
                    pos_next = p;
                    if (pos_reg < tot_reg - `HRR_CRC_LEN) begin
                        crc_next = crc_fed;
                    end
                    if (p == tot_reg) begin
                        state_next = S_IDLE;
                        crc_next = `HRR_CRC_PRESET;
                    end else if (p == tot_reg - 8'h01) begin
                        tx_data_next = crc_reg[15:8];
                    end else if (p == tot_reg - `HRR_CRC_LEN) begin
                        tx_data_next = crc_fed[7:0];
                    end else if (p == 8'h01) begin
                        tx_data_next = err_reg ? (buf_reg[1] | `HRR_ERR_FLAG)
                                       : `HRR_FC_READ;
                    end else if (p == 8'h02) begin
                        tx_data_next = err_reg ? exc_reg : bc;
                    end else if (!rel[0]) begin
                        rd_addr_next = start_idx + {9'h000, rel[7:1]};
                        state_next = S_FETCH;
                    end else begin
                        tx_data_next = word_reg[7:0];
                    end
                end
            end
            S_FETCH: begin
                state_next = S_LOAD;
            end
            S_LOAD: begin
                word_next = rd_data;
                tx_data_next = rd_data[15:8];
                state_next = S_TX;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= S_IDLE;
            for (int i = 0; i < `HRR_BUF_DEPTH; i++) begin
                buf_reg[i] <= 8'h00;
            end
            len_reg <= 4'h0;
            crc_reg <= `HRR_CRC_PRESET;
            crc_d1_reg <= `HRR_CRC_PRESET;
            crc_d2_reg <= `HRR_CRC_PRESET;
            last1_reg <= 8'h00;
            last2_reg <= 8'h00;
            pos_reg <= 8'h00;
            tot_reg <= 8'h00;
            err_reg <= 1'b0;
            exc_reg <= 8'h00;
            word_reg <= 16'h0000;
            rd_addr_reg <= 16'h0000;
            tx_data_reg <= 8'h00;
            wr_allowed_reg <= 1'b0;
            frame_err_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            for (int i = 0; i < `HRR_BUF_DEPTH; i++) begin
                buf_reg[i] <= buf_next[i];
            end
            len_reg <= len_next;
            crc_reg <= crc_next;
            crc_d1_reg <= crc_d1_next;
            crc_d2_reg <= crc_d2_next;
            last1_reg <= last1_next;
            last2_reg <= last2_next;
            pos_reg <= pos_next;
            tot_reg <= tot_next;
            err_reg <= err_next;
            exc_reg <= exc_next;
            word_reg <= word_next;
            rd_addr_reg <= rd_addr_next;
            tx_data_reg <= tx_data_next;
            wr_allowed_reg <= wr_allowed_next;
            frame_err_reg <= frame_err_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign tx_valid = (state_reg == S_TX);
    assign tx_data = tx_data_reg;
    assign tx_last = tx_valid && (p == tot_reg);
    assign rd.en = (state_reg == S_FETCH);
    assign rd.addr = rd_addr_reg;
    assign wr_allowed = wr_allowed_reg;
    assign frame_err = frame_err_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_bad_crc_drop;
        @(posedge ref_clk) disable iff (!rstn)
        (state_reg == S_CHECK) && len_ok && !crc_ok |=> (state_reg == S_IDLE) && frame_err;
    endproperty
    a_bad_crc_drop: assert property (p_bad_crc_drop) else $error("bad crc frame answered");

    property p_bcast_drop;
        @(posedge ref_clk) disable iff (!rstn)
        (state_reg == S_CHECK) && (buf_reg[0] == `HRR_BCAST_ADDR) |=> !tx_valid ##1 !tx_valid;
    endproperty
    a_bcast_drop: assert property (p_bcast_drop) else $error("broadcast read answered");

    property p_first_byte;
        @(posedge ref_clk) disable iff (!rstn)
        (state_reg == S_CHECK) && !drop |=> tx_valid && (tx_data == my_addr) && (pos_reg == 8'h00);
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("response does not open with address");

    property p_err_func;
        @(posedge ref_clk) disable iff (!rstn)
        tx_valid && err_reg && (pos_reg == 8'h01) |-> tx_data == (buf_reg[1] | `HRR_ERR_FLAG);
    endproperty
    a_err_func: assert property (p_err_func) else $error("error function byte wrong");

    property p_unsupported;
        @(posedge ref_clk) disable iff (!rstn)
        (state_reg == S_CHECK) && !drop && err_func |=> err_reg && (tot_reg == `HRR_ERR_LEN);
    endproperty
    a_unsupported: assert property (p_unsupported) else $error("unsupported function not refused");

    property p_byte_count;
        @(posedge ref_clk) disable iff (!rstn)
        tx_valid && !err_reg && (pos_reg == 8'h02) |-> (tx_data == {buf_reg[5][6:0], 1'b0})
            && (tx_data >= `HRR_BC_MIN) && (tx_data <= `HRR_BC_MAX);
    endproperty
    a_byte_count: assert property (p_byte_count) else $error("byte count wrong");

    property p_fetch_order;
        @(posedge ref_clk) disable iff (!rstn)
        rd.en |-> (rd.addr == 16'(start_idx + {9'h000, pos_reg[7:1]} - 16'h0001))
            ##2 (tx_valid && tx_data == $past(rd_data[15:8], 1));
    endproperty
    a_fetch_order: assert property (p_fetch_order) else $error("register order or byte order wrong");

    property p_crc_tail;
        @(posedge ref_clk) disable iff (!rstn)
        tx_valid && tx_ready && (pos_reg == tot_reg - `HRR_CRC_LEN) |-> (tx_data == crc_reg[7:0])
            ##1 (tx_valid && tx_last && tx_data == $past(crc_reg[15:8], 1));
    endproperty
    a_crc_tail: assert property (p_crc_tail) else $error("crc tail not low then high");

    property p_count_limit;
        @(posedge ref_clk) disable iff (!rstn)
        (state_reg == S_CHECK) && !drop && !err_func && !cnt_ok |=> err_reg
            && (exc_reg == `HRR_EXC_VALUE);
    endproperty
    a_count_limit: assert property (p_count_limit) else $error("over-long read not refused");

endmodule // hrr_read_slave

`default_nettype wire
